// File: dv/ccr_config_props.sv
// Checker for the configuration register bank ports
// Assumes a bind onto ccr_config_regs, one clock, synchronous reset
`default_nettype none
module ccr_config_props (
  input wire logic       clk, rst, wr_en, sw_start, sw_stop, converting,
  input wire logic [7:0] wr_addr, wr_data, rd_addr, rd_data,
  input wire logic       reference_range_select, input_range_select, eff_input_range_2x,
  input wire logic       auto_standby_select, standby_active, sw_start_eff, sw_stop_eff,
  input wire logic [1:0] start_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire w5 = wr_en && wr_addr == 8'h05;
  wire w6 = wr_en && wr_addr == 8'h06;
  a_range_write: assert property (w5 ##1 (rd_addr == 8'h05 && !wr_en) |=>
    rd_data == ($past(wr_data, 2) & 8'h7b)) else $error("range register readback wrong");
  a_mode_write: assert property (w6 ##1 (rd_addr == 8'h06 && !wr_en) |=>
    rd_data == ($past(wr_data, 2) & 8'hbf)) else $error("mode register readback wrong");
  a_ref_field: assert property (w5 |=> reference_range_select == $past(wr_data[6]))
    else $error("reference range not updated");
  a_inp_field: assert property (w5 |=> input_range_select == $past(wr_data[5]))
    else $error("input range not updated");
  a_eff_range: assert property (eff_input_range_2x == (input_range_select &&
    !reference_range_select)) else $error("effective range not forced");
  a_start_field: assert property (w6 |=> start_mode == $past(wr_data[4:3]))
    else $error("start mode not updated");
  a_sync_block: assert property ((sw_start || sw_stop) && start_mode == 2'h2 |=>
    !sw_start_eff && !sw_stop_eff) else $error("command passed in sync mode");
  a_stby_enter: assert property (auto_standby_select && !converting ##1
    auto_standby_select |-> standby_active) else $error("standby not entered");
  a_stby_wake: assert property (converting |=> !standby_active)
    else $error("standby held while converting");
  a_stby_idle: assert property (!auto_standby_select ##1 !auto_standby_select
    |-> !standby_active) else $error("standby without select");
  c_sync_mode: cover property (w6 && wr_data[4:3] == 2'h2);
  c_start_cmd: cover property (sw_start_eff);
  c_standby: cover property (standby_active);
endmodule // ccr_config_props
bind ccr_config_regs ccr_config_props u_props (
  .clk(clk), .rst(rst), .wr_en(wr_en), .sw_start(sw_start), .sw_stop(sw_stop),
  .converting(converting), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
  .rd_data(rd_data), .reference_range_select(reference_range_select),
  .input_range_select(input_range_select), .eff_input_range_2x(eff_input_range_2x),
  .auto_standby_select(auto_standby_select), .standby_active(standby_active),
  .sw_start_eff(sw_start_eff), .sw_stop_eff(sw_stop_eff), .start_mode(start_mode)
);
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the configuration register bank
// Assumes ccr_config_regs and its defines header on the include path
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst = 1, wr_en = 0, sw_start = 0, sw_stop = 0, converting = 0;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00;
  wire  [7:0] rd_data;
  wire  [1:0] start_mode;
  wire reference_range_select, input_range_select, eff_input_range_2x, common_mode_output_enable;
  wire positive_reference_buffer_enable, positive_input_buffer_enable, negative_input_buffer_enable;
  wire extended_range_select, data_out_pin_function, speed_low, auto_standby_select, cfg2_bit0;
  wire sw_start_eff, sw_stop_eff, standby_active;
  int error_cnt = 0, check_count = 0;
  logic [7:0] v [6] = '{8'hff, 8'ha5, 8'h08, 8'h10, 8'h5a, 8'h00};
  logic [7:0] m = 8'h00;
  wire  [7:0] range_fields = {1'b0, reference_range_select, input_range_select,
    common_mode_output_enable, positive_reference_buffer_enable, 1'b0,
    positive_input_buffer_enable, negative_input_buffer_enable};
  wire  [7:0] mode_fields = {extended_range_select, 1'b0, data_out_pin_function,
    start_mode, speed_low, auto_standby_select, cfg2_bit0};
  ccr_config_regs dut (
    .clk(clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .sw_start(sw_start), .sw_stop(sw_stop),
    .converting(converting), .reference_range_select(reference_range_select),
    .input_range_select(input_range_select), .eff_input_range_2x(eff_input_range_2x),
    .common_mode_output_enable(common_mode_output_enable),
    .positive_reference_buffer_enable(positive_reference_buffer_enable),
    .positive_input_buffer_enable(positive_input_buffer_enable),
    .negative_input_buffer_enable(negative_input_buffer_enable),
    .extended_range_select(extended_range_select),
    .data_out_pin_function(data_out_pin_function), .start_mode(start_mode),
    .speed_low(speed_low), .auto_standby_select(auto_standby_select),
    .cfg2_bit0(cfg2_bit0), .sw_start_eff(sw_start_eff), .sw_stop_eff(sw_stop_eff),
    .standby_active(standby_active)
  );
  always #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    step(1);
    wr_en = 0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    step(1);
    chk(rd_data, e);
  endtask
  task automatic cmd(input logic [1:0] s, input logic [1:0] e);
    {sw_start, sw_stop} = s;
    step(1);
    {sw_start, sw_stop} = 2'b00;
    chk({6'h00, sw_start_eff, sw_stop_eff}, {6'h00, e});
    step(1);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    step(16);
    rst = 0;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    foreach (v[i])
    begin
      wr(8'h05, v[i]);
      rd(8'h05, v[i] & 8'h7b);
      chk({7'h00, eff_input_range_2x}, {7'h00, v[i][5] & ~v[i][6]});
      chk(range_fields, v[i] & 8'h7b);
      m = (v[i][4:3] == 2'h3) ? (v[i] & 8'hef) : v[i];
      wr(8'h06, m);
      rd(8'h06, m & 8'hbf);
      chk({6'h00, start_mode}, {6'h00, m[4:3]});
      chk(mode_fields, m & 8'hbf);
    end
    wr(8'h07, 8'hff);
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h10);
    cmd(2'b10, 2'b00);
    cmd(2'b01, 2'b00);
    wr(8'h06, 8'h02);
    cmd(2'b10, 2'b10);
    cmd(2'b01, 2'b01);
    chk({7'h00, standby_active}, 8'h01);
    converting = 1;
    step(2);
    chk({7'h00, standby_active}, 8'h00);
    wr(8'h06, 8'h00);
    converting = 0;
    step(2);
    chk({7'h00, standby_active}, 8'h00);
    finish_test;
  end
endmodule // testbench
`default_nettype wire

// File: rtl/ccr_config_regs.v
// Configuration register bank: range, buffer, pin function, start mode, speed, standby
// Assumes the serial core presents decoded one-cycle write strobes and byte data on clk
`default_nettype none
`include "ccr_defines.vh"
// Behaviour
// (R1) Bit 6 of range register selects low or high reference range.
// (R2) High reference range forces effective input range to 1x.
// (R3) Bit 5 of range register selects 1x or 2x input range.
// (R4) Bit 4 of range register enables common-mode output pin.
// (R5) Bit 3 of range register enables positive reference precharge buffer.
// (R6) Bit 1 of range register enables positive input precharge buffer.
// (R7) Bit 0 of range register enables negative input precharge buffer.
// (R8) Bit 7 of mode register selects 25% extended input range.
// (R9) Bit 5 of mode register selects data-only or dual data-ready pin function.
// (R10) Host should use data-only pin function for daisy chains.
// (R11) Bits 4:3 of mode register select start-pin control mode; 11b reserved.
// (R12) Bit 2 of mode register selects high or low speed clock mode.
// (R13) Standby select zero keeps converter powered while idle.
// (R14) Standby select one powers down when stopped, wakes on restart.
// (R15) Mode register sits at address 6h, resets to zero.
// (R16) Synchronized mode blocks software start and stop commands.
// (R17) Reserved bits read zero and ignore writes.
// (R18) Host must not write reserved start-mode code.
module ccr_config_regs
(
  input  wire       clk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  input  wire       sw_start,
  input  wire       sw_stop,
  input  wire       converting,
  output reg        reference_range_select,
  output reg        input_range_select,
  output reg        eff_input_range_2x,
  output reg        common_mode_output_enable,
  output reg        positive_reference_buffer_enable,
  output reg        positive_input_buffer_enable,
  output reg        negative_input_buffer_enable,
  output reg        extended_range_select,
  output reg        data_out_pin_function,
  output reg  [1:0] start_mode,
  output reg        speed_low,
  output reg        auto_standby_select,
  output reg        cfg2_bit0,
  output reg        sw_start_eff,
  output reg        sw_stop_eff,
  output reg        standby_active
);

  // Writable bits per register; zero bits are reserved and read back zero
  localparam [7:0] RANGE_MASK = `CCR_MASK_RANGE_BUF;
  localparam [7:0] MODE_MASK  = `CCR_MASK_MODE_CFG;
  localparam [7:0] RANGE_RST  = `CCR_RST_RANGE_BUF;
  localparam [7:0] MODE_RST   = `CCR_RST_MODE_CFG;

  reg  [7:0] range_buffer_configuration_r;
  wire [7:0] range_buffer_configuration_nxt;
  reg  [7:0] mode_configuration_r;
  wire [7:0] mode_configuration_nxt;
  reg  [7:0] rd_data_nxt;
  wire       range_wr;
  wire       mode_wr;
  wire       sync_mode;
  wire       cmd_conflict;

  assign range_wr     = wr_en & (wr_addr == `CCR_ADDR_RANGE_BUF);
  assign mode_wr      = wr_en & (wr_addr == `CCR_ADDR_MODE_CFG); // (R15)
  assign sync_mode    = (mode_configuration_r[`CCR_B_START_HI:`CCR_B_START_LO] == `CCR_START_SYNC);
  // Start and stop together cancel each other
  assign cmd_conflict = sw_start & sw_stop;

  // Per-bit next value; reserved bits are masked to zero on every write
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bit
      assign range_buffer_configuration_nxt[gi] = range_wr ?
                                                  (wr_data[gi] & RANGE_MASK[gi]) :
                                                  range_buffer_configuration_r[gi]; // (R17)
      assign mode_configuration_nxt[gi]         = mode_wr ?
                                                  (wr_data[gi] & MODE_MASK[gi]) :
                                                  mode_configuration_r[gi]; // (R17)
    end
  endgenerate

  always @*
  begin
    case (rd_addr)
      `CCR_ADDR_RANGE_BUF: rd_data_nxt = range_buffer_configuration_r;
      `CCR_ADDR_MODE_CFG:  rd_data_nxt = mode_configuration_r;
      default:             rd_data_nxt = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      range_buffer_configuration_r <= RANGE_RST;
    end
    else
    begin
      range_buffer_configuration_r <= range_buffer_configuration_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      mode_configuration_r <= MODE_RST; // (R15)
    end
    else
    begin
      mode_configuration_r <= mode_configuration_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= rd_data_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      reference_range_select <= 1'b0;
    end
    else
    begin
      reference_range_select <= range_buffer_configuration_nxt[`CCR_B_REF_RANGE]; // (R1)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      input_range_select <= 1'b0;
    end
    else
    begin
      input_range_select <= range_buffer_configuration_nxt[`CCR_B_IN_RANGE]; // (R3)
    end
  end

  // High reference overrides the stored range bit
  always @(posedge clk)
  begin
    if (rst)
    begin
      eff_input_range_2x <= 1'b0;
    end
    else
    begin
      eff_input_range_2x <= range_buffer_configuration_nxt[`CCR_B_IN_RANGE] &
                            ~range_buffer_configuration_nxt[`CCR_B_REF_RANGE]; // (R2)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      common_mode_output_enable <= 1'b0;
    end
    else
    begin
      common_mode_output_enable <= range_buffer_configuration_nxt[`CCR_B_CM_OUT]; // (R4)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      positive_reference_buffer_enable <= 1'b0;
    end
    else
    begin
      positive_reference_buffer_enable <= range_buffer_configuration_nxt[`CCR_B_PREF]; // (R5)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      positive_input_buffer_enable <= 1'b0;
    end
    else
    begin
      positive_input_buffer_enable <= range_buffer_configuration_nxt[`CCR_B_PIN]; // (R6)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      negative_input_buffer_enable <= 1'b0;
    end
    else
    begin
      negative_input_buffer_enable <= range_buffer_configuration_nxt[`CCR_B_NIN]; // (R7)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      extended_range_select <= 1'b0;
    end
    else
    begin
      extended_range_select <= mode_configuration_nxt[`CCR_B_XRANGE]; // (R8)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      data_out_pin_function <= 1'b0;
    end
    else
    begin
      data_out_pin_function <= mode_configuration_nxt[`CCR_B_DOUT_FN]; // (R9)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      start_mode <= 2'h0;
    end
    else
    begin
      start_mode <= mode_configuration_nxt[`CCR_B_START_HI:`CCR_B_START_LO]; // (R11)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      speed_low <= 1'b0;
    end
    else
    begin
      speed_low <= mode_configuration_nxt[`CCR_B_SPEED]; // (R12)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      auto_standby_select <= 1'b0;
    end
    else
    begin
      auto_standby_select <= mode_configuration_nxt[`CCR_B_STBY]; // (R14)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cfg2_bit0 <= 1'b0;
    end
    else
    begin
      cfg2_bit0 <= mode_configuration_nxt[`CCR_B_CFG2_LSB];
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      sw_start_eff <= 1'b0;
    end
    else
    begin
      sw_start_eff <= sw_start & ~cmd_conflict & ~sync_mode; // (R16)
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      sw_stop_eff <= 1'b0;
    end
    else
    begin
      sw_stop_eff <= sw_stop & ~cmd_conflict & ~sync_mode; // (R16)
    end
  end

  // Standby only when enabled and stopped; idle stays powered otherwise
  always @(posedge clk)
  begin
    if (rst)
    begin
      standby_active <= 1'b0;
    end
    else
    begin
      standby_active <= mode_configuration_r[`CCR_B_STBY] & ~converting; // (R13) (R14)
    end
  end

endmodule // ccr_config_regs
`default_nettype wire

// File: rtl/ccr_defines.vh
// Register offsets, field positions and reset values for the converter configuration bank
// Assumes an 8-bit register address and data path from the serial interface core
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
`define CCR_ADDR_RANGE_BUF      8'h05
`define CCR_ADDR_MODE_CFG       8'h06
`define CCR_RST_RANGE_BUF       8'h00
`define CCR_RST_MODE_CFG        8'h00
`define CCR_MASK_RANGE_BUF      8'h7b
`define CCR_MASK_MODE_CFG       8'hbf
`define CCR_B_REF_RANGE         6
`define CCR_B_IN_RANGE          5
`define CCR_B_CM_OUT            4
`define CCR_B_PREF              3
`define CCR_B_PIN               1
`define CCR_B_NIN               0
`define CCR_B_XRANGE            7
`define CCR_B_DOUT_FN           5
`define CCR_B_START_HI          4
`define CCR_B_START_LO          3
`define CCR_B_SPEED             2
`define CCR_B_STBY              1
`define CCR_B_CFG2_LSB          0
`define CCR_START_STOP          2'h0
`define CCR_START_ONESHOT       2'h1
`define CCR_START_SYNC          2'h2
`define CCR_START_RSVD          2'h3
`endif
